// *** sdcsd_pkg.sv ***
// Constants and types for the two-bank DRAM command decoder.
// Assumes a single 40 MHz clock; used by sdcsd_top and sdcsd_bank.
`default_nettype none
package sdcsd_pkg;

  // Clock period and the row cycle wait after self-refresh exit
  localparam int unsigned CLK_PERIOD_NS      = 25;
  localparam int unsigned ROW_CYCLE_TIME_NS  = 70;
  localparam int unsigned ROW_CYCLE_CYC      =
    (ROW_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RC_CNT_W           = 4;

  // Address field positions
  localparam int unsigned ADDR_W             = 12;
  localparam int unsigned BANK_BIT           = 11;
  localparam int unsigned AUTO_BIT           = 10;
  localparam int unsigned ROW_W              = 11;
  localparam int unsigned COL_W              = 8;

  // Command codes as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CODE_NOP            = 4'h7;
  localparam logic [3:0] CODE_BURST_STOP     = 4'h6;
  localparam logic [3:0] CODE_READ           = 4'h5;
  localparam logic [3:0] CODE_WRITE          = 4'h4;
  localparam logic [3:0] CODE_ROW_OPEN       = 4'h3;
  localparam logic [3:0] CODE_BANK_CLOSE     = 4'h2;
  localparam logic [3:0] CODE_RECHARGE       = 4'h1;
  localparam logic [3:0] CODE_CONFIG_LOAD    = 4'h0;

  // Decoded command
  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_BURST_STOP, CMD_READ, CMD_WRITE,
    CMD_ROW_OPEN, CMD_BANK_CLOSE, CMD_RECHARGE, CMD_CONFIG_LOAD
  } sdcsd_cmd_e;

  // Per-bank state
  typedef enum logic [2:0] {
    BANK_IDLE, BANK_ACTIVE, BANK_READ, BANK_WRITE,
    BANK_READ_CLOSE, BANK_WRITE_CLOSE
  } sdcsd_bank_e;

  // Device power state
  typedef enum logic [2:0] {
    PWR_NORMAL, PWR_SELF_REFRESH, PWR_SR_RECOVERY, PWR_POWER_DOWN, PWR_SUSPEND
  } sdcsd_pwr_e;

endpackage
`default_nettype wire

// *** sdcsd_bank.sv ***
// Next-state logic of one bank for a decoded command.
// Assumes the command is only applied while the device is in normal operation.
`default_nettype none
module sdcsd_bank (
  // Command
  input  wire logic                 cmd_valid,
  input  var  sdcsd_pkg::sdcsd_cmd_e cmd,
  input  wire logic                 this_bank,
  input  wire logic                 auto_close,
  // State
  input  var  sdcsd_pkg::sdcsd_bank_e cur,
  output var  sdcsd_pkg::sdcsd_bank_e nxt
);

  ////////////////////////////////////////////////////////////////////////////
  // Transition table; a read or write for the other bank ends any burst here
  always_comb begin
    nxt = cur;
    if (cmd_valid) begin
      unique case (cmd)
        sdcsd_pkg::CMD_BURST_STOP: begin
          if (cur != sdcsd_pkg::BANK_IDLE)
            nxt = sdcsd_pkg::BANK_ACTIVE;
        end
        sdcsd_pkg::CMD_READ: begin
          if (this_bank)
            nxt = auto_close ? sdcsd_pkg::BANK_READ_CLOSE : sdcsd_pkg::BANK_READ;
          else if (cur != sdcsd_pkg::BANK_IDLE)
            nxt = sdcsd_pkg::BANK_ACTIVE;
        end
        sdcsd_pkg::CMD_WRITE: begin
          if (this_bank)
            nxt = auto_close ? sdcsd_pkg::BANK_WRITE_CLOSE : sdcsd_pkg::BANK_WRITE;
          else if (cur != sdcsd_pkg::BANK_IDLE)
            nxt = sdcsd_pkg::BANK_ACTIVE;
        end
        sdcsd_pkg::CMD_ROW_OPEN: begin
          if (this_bank && cur == sdcsd_pkg::BANK_IDLE)
            nxt = sdcsd_pkg::BANK_ACTIVE;
        end
        sdcsd_pkg::CMD_BANK_CLOSE: begin
          if (auto_close || this_bank)
            nxt = sdcsd_pkg::BANK_IDLE;
        end
        sdcsd_pkg::CMD_RECHARGE, sdcsd_pkg::CMD_CONFIG_LOAD: begin
          nxt = sdcsd_pkg::BANK_IDLE;
        end
        default: nxt = cur;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** sdcsd_top.sv ***
// Command decoder and bank/power state of a two-bank synchronous DRAM.
// Assumes a controller on the same clock; pins still pass two flip-flops.
`default_nettype none
module sdcsd_top (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // Command pins from the controller
  input  wire logic                       cke,
  input  wire logic                       cs_n,
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic [sdcsd_pkg::ADDR_W-1:0] addr,
  // Decoded state
  output logic [2:0]                      bank0_state,
  output logic [2:0]                      bank1_state,
  output logic [2:0]                      power_state,
  output logic                            internal_clk_en,
  output logic [3:0]                      cmd_code,
  output logic                            cmd_strobe,
  output logic                            illegal_cmd,
  output logic                            self_refresh_run,
  output logic [sdcsd_pkg::ROW_W-1:0]     row_addr,
  output logic [sdcsd_pkg::COL_W-1:0]     col_addr,
  output logic                            config_strobe,
  output logic [sdcsd_pkg::ADDR_W-1:0]    config_word
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [1:0]                     cke_sync;
    logic [1:0]                     cs_sync;
    logic [1:0]                     ras_sync;
    logic [1:0]                     cas_sync;
    logic [1:0]                     we_sync;
    logic [sdcsd_pkg::ADDR_W-1:0]   addr_s1;
    logic [sdcsd_pkg::ADDR_W-1:0]   addr_s2;
    logic                           cke_prev;
    sdcsd_pkg::sdcsd_pwr_e          pwr;
    sdcsd_pkg::sdcsd_bank_e         bank0;
    sdcsd_pkg::sdcsd_bank_e         bank1;
    logic [sdcsd_pkg::RC_CNT_W-1:0] rc_cnt;
    logic [3:0]                     cmd_code;
    logic                           cmd_strobe;
    logic                           illegal;
    logic [sdcsd_pkg::ROW_W-1:0]    row_addr;
    logic [sdcsd_pkg::COL_W-1:0]    col_addr;
    logic                           cfg_strobe;
    logic [sdcsd_pkg::ADDR_W-1:0]   cfg_word;
    logic                           sr_run;
  } sdcsd_state_s;

  sdcsd_state_s           st_q;
  sdcsd_state_s           st_d;
  logic [1:0]             rst_sync_q;
  logic                   rst_sync_n;
  logic                   cke_now;
  logic                   cke_was;
  logic [3:0]             code;
  sdcsd_pkg::sdcsd_cmd_e  cmd;
  logic                   both_idle;
  logic                   cmd_live;
  sdcsd_pkg::sdcsd_bank_e nxt0;
  sdcsd_pkg::sdcsd_bank_e nxt1;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; kept out of the state struct because
  // it runs on the raw pin reset and the struct register runs on its output
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_sync_n = rst_sync_q[1];

  // Pin view after two flops; cke_prev holds the sample of the edge before
  assign cke_now = st_q.cke_sync[1];
  assign cke_was = st_q.cke_prev;
  assign code    = {st_q.cs_sync[1], st_q.ras_sync[1], st_q.cas_sync[1], st_q.we_sync[1]};

  // Command decode; chip select high is deselect whatever the rest shows
  always_comb begin
    cmd = sdcsd_pkg::CMD_DESELECT;
    if (!code[3]) begin
      unique case (code)
        sdcsd_pkg::CODE_NOP:         cmd = sdcsd_pkg::CMD_NOP;
        sdcsd_pkg::CODE_BURST_STOP:  cmd = sdcsd_pkg::CMD_BURST_STOP;
        sdcsd_pkg::CODE_READ:        cmd = sdcsd_pkg::CMD_READ;
        sdcsd_pkg::CODE_WRITE:       cmd = sdcsd_pkg::CMD_WRITE;
        sdcsd_pkg::CODE_ROW_OPEN:    cmd = sdcsd_pkg::CMD_ROW_OPEN;
        sdcsd_pkg::CODE_BANK_CLOSE:  cmd = sdcsd_pkg::CMD_BANK_CLOSE;
        sdcsd_pkg::CODE_RECHARGE:    cmd = sdcsd_pkg::CMD_RECHARGE;
        default:                     cmd = sdcsd_pkg::CMD_CONFIG_LOAD;
      endcase
    end
  end

  assign both_idle = (st_q.bank0 == sdcsd_pkg::BANK_IDLE) &&
                     (st_q.bank1 == sdcsd_pkg::BANK_IDLE);
  // Banks move only in normal operation with enable high on both samples
  assign cmd_live  = (st_q.pwr == sdcsd_pkg::PWR_NORMAL) && cke_was && cke_now;

  ////////////////////////////////////////////////////////////////////////////
  // Bank next-state, one instance per bank
  sdcsd_bank u_bank0 (
    .cmd_valid  (cmd_live),
    .cmd        (cmd),
    .this_bank  (!st_q.addr_s2[sdcsd_pkg::BANK_BIT]),
    .auto_close (st_q.addr_s2[sdcsd_pkg::AUTO_BIT]),
    .cur        (st_q.bank0),
    .nxt        (nxt0)
  );

  sdcsd_bank u_bank1 (
    .cmd_valid  (cmd_live),
    .cmd        (cmd),
    .this_bank  (st_q.addr_s2[sdcsd_pkg::BANK_BIT]),
    .auto_close (st_q.addr_s2[sdcsd_pkg::AUTO_BIT]),
    .cur        (st_q.bank1),
    .nxt        (nxt1)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state of everything
  always_comb begin
    st_d            = st_q;
    st_d.cke_sync   = {st_q.cke_sync[0], cke};
    st_d.cs_sync    = {st_q.cs_sync[0], cs_n};
    st_d.ras_sync   = {st_q.ras_sync[0], ras_n};
    st_d.cas_sync   = {st_q.cas_sync[0], cas_n};
    st_d.we_sync    = {st_q.we_sync[0], we_n};
    st_d.addr_s1    = addr;
    st_d.addr_s2    = st_q.addr_s1;
    st_d.cke_prev   = cke_now;
    st_d.cmd_strobe = 1'b0;
    st_d.cfg_strobe = 1'b0;
    st_d.illegal    = 1'b0;
    st_d.bank0      = nxt0;
    st_d.bank1      = nxt1;
    if (cmd_live) begin
      st_d.cmd_code   = code;
      st_d.cmd_strobe = (cmd != sdcsd_pkg::CMD_DESELECT);
    end
    // Address capture for row open, column and config load commands
    if (cmd_live && cmd == sdcsd_pkg::CMD_ROW_OPEN)
      st_d.row_addr = st_q.addr_s2[sdcsd_pkg::ROW_W-1:0];
    if (cmd_live && (cmd == sdcsd_pkg::CMD_READ || cmd == sdcsd_pkg::CMD_WRITE))
      st_d.col_addr = st_q.addr_s2[sdcsd_pkg::COL_W-1:0];
    if (cmd_live && cmd == sdcsd_pkg::CMD_CONFIG_LOAD && both_idle) begin
      st_d.cfg_strobe = 1'b1;
      st_d.cfg_word   = st_q.addr_s2;
    end
    // Power state machine
    unique case (st_q.pwr)
      sdcsd_pkg::PWR_NORMAL: begin
        if (cke_was && !cke_now) begin
          if (both_idle && cmd == sdcsd_pkg::CMD_RECHARGE) begin
            st_d.pwr   = sdcsd_pkg::PWR_SELF_REFRESH;
            st_d.bank0 = sdcsd_pkg::BANK_IDLE;
            st_d.bank1 = sdcsd_pkg::BANK_IDLE;
          end else if (!both_idle) begin
            st_d.pwr = sdcsd_pkg::PWR_SUSPEND;
          end
        end else if (!cke_was && both_idle) begin
          st_d.pwr = sdcsd_pkg::PWR_POWER_DOWN;
        end else if (!cke_was) begin
          st_d.pwr = sdcsd_pkg::PWR_SUSPEND;
        end
      end
      sdcsd_pkg::PWR_SELF_REFRESH: begin
        // Only the enable pin decides the exit; the command only sets the illegal flag
        if (!cke_was && cke_now) begin
          st_d.pwr     = sdcsd_pkg::PWR_SR_RECOVERY;
          st_d.rc_cnt  = sdcsd_pkg::RC_CNT_W'(sdcsd_pkg::ROW_CYCLE_CYC);
          st_d.illegal = (cmd != sdcsd_pkg::CMD_DESELECT) && (cmd != sdcsd_pkg::CMD_NOP);
        end
      end
      sdcsd_pkg::PWR_SR_RECOVERY: begin
        if (cke_was && !cke_now && (cmd == sdcsd_pkg::CMD_DESELECT || cmd == sdcsd_pkg::CMD_NOP))
          st_d.pwr = sdcsd_pkg::PWR_POWER_DOWN;
        else if (cke_was && cke_now) begin
          st_d.illegal = (cmd != sdcsd_pkg::CMD_DESELECT) && (cmd != sdcsd_pkg::CMD_NOP);
          if (st_q.rc_cnt <= 4'h1)
            st_d.pwr = sdcsd_pkg::PWR_NORMAL;
          else
            st_d.rc_cnt = st_q.rc_cnt - 4'h1;
        end
      end
      sdcsd_pkg::PWR_POWER_DOWN: begin
        if (cke_now)
          st_d.pwr = sdcsd_pkg::PWR_NORMAL;
      end
      sdcsd_pkg::PWR_SUSPEND: begin
        if (cke_now)
          st_d.pwr = sdcsd_pkg::PWR_NORMAL;
      end
    endcase
    // Registered so the self-refresh flag leaves the block from a flop
    st_d.sr_run = (st_d.pwr == sdcsd_pkg::PWR_SELF_REFRESH);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register on the synchronised reset
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_q.cke_sync   <= 2'h0;
      st_q.cs_sync    <= 2'h3;
      st_q.ras_sync   <= 2'h3;
      st_q.cas_sync   <= 2'h3;
      st_q.we_sync    <= 2'h3;
      st_q.addr_s1    <= 12'h000;
      st_q.addr_s2    <= 12'h000;
      st_q.cke_prev   <= 1'b0;
      st_q.pwr        <= sdcsd_pkg::PWR_NORMAL;
      st_q.bank0      <= sdcsd_pkg::BANK_IDLE;
      st_q.bank1      <= sdcsd_pkg::BANK_IDLE;
      st_q.rc_cnt     <= 4'h0;
      st_q.cmd_code   <= 4'hf;
      st_q.cmd_strobe <= 1'b0;
      st_q.illegal    <= 1'b0;
      st_q.row_addr   <= 11'h000;
      st_q.col_addr   <= 8'h00;
      st_q.cfg_strobe <= 1'b0;
      st_q.cfg_word   <= 12'h000;
      st_q.sr_run     <= 1'b0;
    end else begin
      st_q.cke_sync   <= st_d.cke_sync;
      st_q.cs_sync    <= st_d.cs_sync;
      st_q.ras_sync   <= st_d.ras_sync;
      st_q.cas_sync   <= st_d.cas_sync;
      st_q.we_sync    <= st_d.we_sync;
      st_q.addr_s1    <= st_d.addr_s1;
      st_q.addr_s2    <= st_d.addr_s2;
      st_q.cke_prev   <= st_d.cke_prev;
      st_q.pwr        <= st_d.pwr;
      st_q.bank0      <= st_d.bank0;
      st_q.bank1      <= st_d.bank1;
      st_q.rc_cnt     <= st_d.rc_cnt;
      st_q.cmd_code   <= st_d.cmd_code;
      st_q.cmd_strobe <= st_d.cmd_strobe;
      st_q.illegal    <= st_d.illegal;
      st_q.row_addr   <= st_d.row_addr;
      st_q.col_addr   <= st_d.col_addr;
      st_q.cfg_strobe <= st_d.cfg_strobe;
      st_q.cfg_word   <= st_d.cfg_word;
      st_q.sr_run     <= st_d.sr_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign bank0_state      = st_q.bank0;
  assign bank1_state      = st_q.bank1;
  assign power_state      = st_q.pwr;
  assign internal_clk_en  = st_q.cke_prev;
  assign cmd_code         = st_q.cmd_code;
  assign cmd_strobe       = st_q.cmd_strobe;
  assign illegal_cmd      = st_q.illegal;
  assign self_refresh_run = st_q.sr_run;
  assign row_addr         = st_q.row_addr;
  assign col_addr         = st_q.col_addr;
  assign config_strobe    = st_q.cfg_strobe;
  assign config_word      = st_q.cfg_word;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_self_refresh_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    st_q.pwr == sdcsd_pkg::PWR_SELF_REFRESH && !cke_now
    |=> st_q.pwr == sdcsd_pkg::PWR_SELF_REFRESH)
    else $error("self-refresh left with enable low");
  a_power_down_exit: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    st_q.pwr == sdcsd_pkg::PWR_POWER_DOWN && cke_now |=> st_q.pwr == sdcsd_pkg::PWR_NORMAL)
    else $error("power-down not left on enable high");
  a_suspend_exit: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    st_q.pwr == sdcsd_pkg::PWR_SUSPEND && cke_now |=> st_q.pwr == sdcsd_pkg::PWR_NORMAL)
    else $error("suspend not ended");
  a_suspend_entry: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    st_q.pwr == sdcsd_pkg::PWR_NORMAL && cke_was && !cke_now && !both_idle
    |=> st_q.pwr == sdcsd_pkg::PWR_SUSPEND)
    else $error("suspend not entered");
  a_self_refresh_entry: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    st_q.pwr == sdcsd_pkg::PWR_NORMAL && cke_was && !cke_now && both_idle &&
    cmd == sdcsd_pkg::CMD_RECHARGE |=> self_refresh_run)
    else $error("self-refresh not entered");
  a_recovery_length: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    $rose(st_q.pwr == sdcsd_pkg::PWR_SR_RECOVERY) && cke_now
    |-> ##[1:3] st_q.pwr != sdcsd_pkg::PWR_SR_RECOVERY)
    else $error("recovery too long");
  a_close_all: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    cmd_live && cmd == sdcsd_pkg::CMD_BANK_CLOSE && st_q.addr_s2[sdcsd_pkg::AUTO_BIT]
    |=> both_idle)
    else $error("close-all left a bank open");
  a_read_auto: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
    cmd_live && cmd == sdcsd_pkg::CMD_READ && st_q.addr_s2[sdcsd_pkg::AUTO_BIT] &&
    st_q.addr_s2[sdcsd_pkg::BANK_BIT] |=> st_q.bank1 == sdcsd_pkg::BANK_READ_CLOSE)
    else $error("read auto-close not set");

endmodule
`default_nettype wire

// *** sdcsd_ctrl_model.sv ***
// Memory controller model that drives the clock-enable, command and address pins.
// Assumes one shared clock; every pin change is made by NBA just after a rising edge.
`default_nettype none
module sdcsd_ctrl_model (
  // Clock
  input  wire logic        sys_clk,
  // Pins towards the device
  output var  logic        cke,
  output var  logic        cs_n,
  output var  logic        ras_n,
  output var  logic        cas_n,
  output var  logic        we_n,
  output var  logic [11:0] addr
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////
  // Pins start as a no-operation with clock-enable high
  initial begin
    cke   = 1'b1;
    cs_n  = 1'b0;
    ras_n = 1'b1;
    cas_n = 1'b1;
    we_n  = 1'b1;
    addr  = 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One command cycle; the code is one from the package table or 4'hf for deselect
  task automatic drive(input logic [3:0] code, input logic [11:0] a, input logic ck);
    @(posedge sys_clk);
    cke <= ck;
    {cs_n, ras_n, cas_n, we_n} <= code;
    addr <= a;
  endtask

  // Idle cycles; the address is don't-care so it flips every cycle
  // to keep a stale value from passing for a live one
  task automatic idle(input int n, input logic ck);
    repeat (n) drive(sdcsd_pkg::CODE_NOP, ~addr, ck);
  endtask

  // Leave a low-power mode: raise clock-enable only with a no-operation
  task automatic wake(input int n);
    drive(sdcsd_pkg::CODE_NOP, ~addr, 1'b1);
    idle(n, 1'b1);
  endtask
endmodule
`default_nettype wire

// *** test_sdcsd_command_state_decode.sv ***
// Self-checking bench for the DRAM command decoder and bank state logic.
// Assumes the controller model drives all command pins; the bench only owns clock and reset.
`default_nettype none
module test_sdcsd_command_state_decode;
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////
  // Wiring
  logic        sys_clk;
  logic        rst_n;
  logic        cke, cs_n, ras_n, cas_n, we_n;
  logic [11:0] addr;
  logic [2:0]  bank0_state, bank1_state, power_state;
  logic        internal_clk_en, cmd_strobe, illegal_cmd, self_refresh_run, config_strobe;
  logic [3:0]  cmd_code;
  logic [10:0] row_addr;
  logic [7:0]  col_addr;
  logic [11:0] config_word;
  int          mismatches;
  int          checked;
  int          cycles;
  int          illegals;

  typedef struct packed {
    logic [3:0]  code;
    logic [11:0] a;
    logic [2:0]  b0;
    logic [2:0]  b1;
  } sdcsd_row_s;

  // Command, address, then expected bank 0 and bank 1 states
  sdcsd_row_s rows [14] = '{
    '{sdcsd_pkg::CODE_ROW_OPEN,    12'h2a5, 3'h1, 3'h0},
    '{sdcsd_pkg::CODE_ROW_OPEN,    12'hc5a, 3'h1, 3'h1},
    '{sdcsd_pkg::CODE_READ,        12'h3ff, 3'h2, 3'h1},
    '{sdcsd_pkg::CODE_READ,        12'hc12, 3'h1, 3'h4},
    '{sdcsd_pkg::CODE_WRITE,       12'h033, 3'h3, 3'h1},
    '{sdcsd_pkg::CODE_WRITE,       12'hd44, 3'h1, 3'h5},
    '{sdcsd_pkg::CODE_BURST_STOP,  12'h000, 3'h1, 3'h1},
    '{sdcsd_pkg::CODE_BANK_CLOSE,  12'h800, 3'h1, 3'h0},
    '{sdcsd_pkg::CODE_ROW_OPEN,    12'h801, 3'h1, 3'h1},
    '{sdcsd_pkg::CODE_READ,        12'h400, 3'h4, 3'h1},
    '{sdcsd_pkg::CODE_BANK_CLOSE,  12'h400, 3'h0, 3'h0},
    '{sdcsd_pkg::CODE_RECHARGE,    12'h000, 3'h0, 3'h0},
    '{sdcsd_pkg::CODE_CONFIG_LOAD, 12'h237, 3'h0, 3'h0},
    '{4'hf,                        12'h5a5, 3'h0, 3'h0}
  };

  sdcsd_ctrl_model u_ctrl (
    .sys_clk (sys_clk),
    .cke     (cke),
    .cs_n    (cs_n),
    .ras_n   (ras_n),
    .cas_n   (cas_n),
    .we_n    (we_n),
    .addr    (addr)
  );

  sdcsd_top dut (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .cke              (cke),
    .cs_n             (cs_n),
    .ras_n            (ras_n),
    .cas_n            (cas_n),
    .we_n             (we_n),
    .addr             (addr),
    .bank0_state      (bank0_state),
    .bank1_state      (bank1_state),
    .power_state      (power_state),
    .internal_clk_en  (internal_clk_en),
    .cmd_code         (cmd_code),
    .cmd_strobe       (cmd_strobe),
    .illegal_cmd      (illegal_cmd),
    .self_refresh_run (self_refresh_run),
    .row_addr         (row_addr),
    .col_addr         (col_addr),
    .config_strobe    (config_strobe),
    .config_word      (config_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the whole run needs a few hundred cycles
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Illegal pulses last one cycle, so they are counted rather than sampled
  always @(posedge sys_clk) begin
    cycles++;
    if (illegal_cmd === 1'b1)
      illegals++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, command step and verdict
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Decode shows three edges after the pins change, while its strobes stand;
  // banks are looked at two edges later
  task automatic step(input logic [3:0] code, input logic [11:0] a);
    u_ctrl.drive(code, a, 1'b1);
    u_ctrl.idle(3, 1'b1);
    #1;
    check(12'(cmd_code), 12'(code));
    check(12'(cmd_strobe), 12'(!code[3]));
    check(12'(config_strobe), 12'(code == sdcsd_pkg::CODE_CONFIG_LOAD));
    u_ctrl.idle(2, 1'b1);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    repeat (7) @(posedge sys_clk);
    #1;
    check(12'(power_state), 12'h000);
    check(12'(bank0_state | bank1_state), 12'h000);
    check(12'(cmd_code), 12'h00f);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    u_ctrl.idle(8, 1'b1);

    // Bank command table; banks are idle at each recharge or load
    foreach (rows[i]) begin
      step(rows[i].code, rows[i].a);
      check(12'(bank0_state), 12'(rows[i].b0));
      check(12'(bank1_state), 12'(rows[i].b1));
      if (rows[i].code == sdcsd_pkg::CODE_ROW_OPEN)
        check(12'(row_addr), 12'(rows[i].a[10:0]));
      if (rows[i].code == sdcsd_pkg::CODE_READ || rows[i].code == sdcsd_pkg::CODE_WRITE)
        check(12'(col_addr), 12'(rows[i].a[7:0]));
      if (rows[i].code == sdcsd_pkg::CODE_CONFIG_LOAD)
        check(config_word, rows[i].a);
    end

    // Power-down with a plain no-operation, then exit
    u_ctrl.drive(sdcsd_pkg::CODE_NOP, 12'h000, 1'b0);
    u_ctrl.idle(5, 1'b0);
    #1;
    check(12'(power_state), 12'h003);
    check(12'(internal_clk_en), 12'h000);
    u_ctrl.wake(5);
    #1;
    check(12'(power_state), 12'h000);
    check(12'(internal_clk_en), 12'h001);

    // Self-refresh; a row open while there must be ignored
    u_ctrl.drive(sdcsd_pkg::CODE_RECHARGE, 12'h000, 1'b0);
    u_ctrl.idle(5, 1'b0);
    #1;
    check(12'(power_state), 12'h001);
    check(12'(self_refresh_run), 12'h001);
    u_ctrl.drive(sdcsd_pkg::CODE_ROW_OPEN, 12'h000, 1'b0);
    u_ctrl.idle(5, 1'b0);
    #1;
    check(12'(power_state), 12'h001);
    check(12'(bank0_state), 12'h000);
    u_ctrl.wake(3);
    #1;
    check(12'(power_state), 12'h002);
    u_ctrl.idle(6, 1'b1);
    #1;
    check(12'(power_state), 12'h000);
    check(12'(self_refresh_run), 12'h000);

    // Clock-enable drops again during recovery
    u_ctrl.drive(sdcsd_pkg::CODE_RECHARGE, 12'h000, 1'b0);
    u_ctrl.idle(5, 1'b0);
    u_ctrl.wake(1);
    u_ctrl.idle(6, 1'b0);
    #1;
    check(12'(power_state), 12'h003);
    u_ctrl.wake(5);
    #1;
    check(12'(power_state), 12'h000);

    // Clock suspend during a read, then resume it
    step(sdcsd_pkg::CODE_ROW_OPEN, 12'h000);
    step(sdcsd_pkg::CODE_READ, 12'h000);
    u_ctrl.idle(5, 1'b0);
    #1;
    check(12'(power_state), 12'h004);
    check(12'(bank0_state), 12'h002);
    u_ctrl.wake(5);
    #1;
    check(12'(power_state), 12'h000);
    check(12'(bank0_state), 12'h002);
    step(sdcsd_pkg::CODE_BANK_CLOSE, 12'h400);
    check(12'(bank0_state), 12'h000);

    // Self-refresh left with a read on the enable rise: flagged once, ignored
    u_ctrl.drive(sdcsd_pkg::CODE_RECHARGE, 12'h000, 1'b0);
    u_ctrl.idle(5, 1'b0);
    u_ctrl.drive(sdcsd_pkg::CODE_READ, 12'h000, 1'b1);
    u_ctrl.idle(8, 1'b1);
    #1;
    check(12'(illegals), 12'h001);
    check(12'(power_state), 12'h000);
    check(12'(bank0_state), 12'h000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
